// *** iocd_top.sv ***
// iocd_top: data-space decoder between core access path and i/o, extended i/o and ram
// assumes: core presents one access per cycle; fuse level is a static pin
`timescale 1ns/100ps
`default_nettype none
module iocd_top (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                srst,
   // fuse pin, high when programmed
   input  wire logic                legacy_compat_fuse,
   // core access
   input  wire iocd_pkg::iocd_req_t core_req,
   // routed access, registered
   output var iocd_pkg::iocd_sel_t  sel_r,
   output logic                     compat_mode_r,
   output logic                     ext_io_en_r,
   output logic [5:0]               vec_count_r,
   output logic                     map_ready_r
);
   // ************************************************************
   // fuse sampling
   // ************************************************************
   logic               fuse_s1_r;
   logic               fuse_s2_r;
   logic               sampled_r;
   iocd_pkg::iocd_sel_t sel_nxt;
   iocd_pkg::iocd_req_t req_gated;

   always_ff @(posedge sys_clk) begin
      fuse_s1_r <= legacy_compat_fuse;
      fuse_s2_r <= fuse_s1_r;
   end

   // latched once after reset release so the map cannot shift mid-program
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sampled_r     <= 1'b0;
         compat_mode_r <= 1'b0;
      end else if (!sampled_r) begin
         sampled_r     <= 1'b1;
         compat_mode_r <= fuse_s2_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         map_ready_r <= 1'b0;
         ext_io_en_r <= 1'b0;
         vec_count_r <= 6'h00;
      end else begin
         map_ready_r <= sampled_r;
         ext_io_en_r <= sampled_r && !compat_mode_r;
         vec_count_r <= !sampled_r ? 6'h00 :
                        (compat_mode_r ? iocd_pkg::VEC_COMP_CNT : iocd_pkg::VEC_NORM_CNT);
      end
   end

   // ************************************************************
   // decode
   // ************************************************************
   // accesses before the map is chosen are dropped
   always_comb begin
      req_gated     = core_req;
      req_gated.vld = core_req.vld && sampled_r;
   end

   iocd_decode u_decode (
      .req    (req_gated),
      .compat (compat_mode_r),
      .sel    (sel_nxt)
   );

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sel_r <= '0;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   // each access is judged against the map latched before it was taken;
   // the map never moves once latched, so compat_mode_r a cycle later is the same
   sequence s_io_req;
      core_req.vld && core_req.io_instr && sampled_r;
   endsequence

   sequence s_mem_req;
      core_req.vld && !core_req.io_instr && sampled_r;
   endsequence

   sequence s_early_req;
      core_req.vld && !sampled_r;
   endsequence

   sequence s_io_mem;
      core_req.vld && !core_req.io_instr && sampled_r
      && core_req.addr >= iocd_pkg::IO_DATA_BASE && core_req.addr < iocd_pkg::EXT_IO_FIRST;
   endsequence

   sequence s_ext_ld;
      core_req.vld && !core_req.io_instr && sampled_r
      && core_req.addr >= iocd_pkg::EXT_IO_FIRST && core_req.addr <= iocd_pkg::EXT_IO_LAST;
   endsequence

   sequence s_ram_norm;
      core_req.vld && !core_req.io_instr && sampled_r && !compat_mode_r
      && core_req.addr >= iocd_pkg::RAM_NORM_BASE
      && core_req.addr < 16'(iocd_pkg::RAM_NORM_BASE + iocd_pkg::RAM_SIZE);
   endsequence

   sequence s_ram_comp;
      core_req.vld && !core_req.io_instr && sampled_r && compat_mode_r
      && core_req.addr >= iocd_pkg::RAM_COMP_BASE
      && core_req.addr < 16'(iocd_pkg::RAM_COMP_BASE + iocd_pkg::RAM_SIZE);
   endsequence

   sequence s_reset_exit;
      $fell(srst);
   endsequence

   sequence s_map_settle;
      ##2 map_ready_r;
   endsequence

   // direct i/o: a 64-location window holding the legacy registers only
   io_window_a: assert property (
      s_io_req and core_req.addr >= iocd_pkg::IO_WIN_SIZE
      |=> sel_r.tgt == iocd_pkg::IOCD_TGT_NONE)
      else $error("io beyond window decoded");

   io_legacy_a: assert property (
      s_io_req and core_req.addr < iocd_pkg::IO_WIN_SIZE
      |=> sel_r.tgt == iocd_pkg::IOCD_TGT_IO && sel_r.addr == $past(core_req.addr))
      else $error("legacy io misrouted");

   io_no_ext_a: assert property (
      s_io_req |=> sel_r.tgt != iocd_pkg::IOCD_TGT_EXT)
      else $error("io instr reached extended io");

   io_mem_win_a: assert property (
      s_io_mem |=> sel_r.tgt == iocd_pkg::IOCD_TGT_IO
      && sel_r.addr == $past(core_req.addr) - iocd_pkg::IO_DATA_BASE)
      else $error("legacy io via memory access misrouted");

   // extended i/o: memory accesses only, and only in the normal map
   ext_normal_a: assert property (
      s_ext_ld and !compat_mode_r |=> sel_r.tgt == iocd_pkg::IOCD_TGT_EXT)
      else $error("extended io not decoded");

   ext_addr_a: assert property (
      s_ext_ld and !compat_mode_r |=> sel_r.addr == $past(core_req.addr))
      else $error("extended io address changed");

   ext_as_ram_a: assert property (
      s_ext_ld and compat_mode_r |=> sel_r.tgt == iocd_pkg::IOCD_TGT_RAM
      && sel_r.addr == $past(core_req.addr) - iocd_pkg::RAM_COMP_BASE)
      else $error("compat ram misplaced");

   compat_no_ext_a: assert property (
      compat_mode_r |=> sel_r.tgt != iocd_pkg::IOCD_TGT_EXT)
      else $error("extended io reached in compat mode");

   ext_off_a: assert property (
      sampled_r && compat_mode_r |=> !ext_io_en_r)
      else $error("ext io active");

   ext_on_a: assert property (
      sampled_r && !compat_mode_r |=> ext_io_en_r)
      else $error("ext io not enabled in normal map");

   // ram placement in both maps
   ram_above_a: assert property (
      s_mem_req and !compat_mode_r && core_req.addr == iocd_pkg::RAM_NORM_BASE
      |=> sel_r.tgt == iocd_pkg::IOCD_TGT_RAM && sel_r.addr == 16'h0000)
      else $error("normal ram base wrong");

   ram_norm_a: assert property (
      s_ram_norm |=> sel_r.tgt == iocd_pkg::IOCD_TGT_RAM
      && sel_r.addr == $past(core_req.addr) - iocd_pkg::RAM_NORM_BASE)
      else $error("normal ram offset wrong");

   ram_no_overlap_a: assert property (
      s_mem_req and !compat_mode_r && core_req.addr < iocd_pkg::RAM_NORM_BASE
      |=> sel_r.tgt != iocd_pkg::IOCD_TGT_RAM)
      else $error("normal ram overlaps extended io");

   compat_ram_a: assert property (
      s_ram_comp |=> sel_r.tgt == iocd_pkg::IOCD_TGT_RAM
      && sel_r.addr == $past(core_req.addr) - iocd_pkg::RAM_COMP_BASE)
      else $error("compat ram offset wrong");

   // map choice: latched once, nothing taken before it, never moves after
   fuse_latch_a: assert property (
      $rose(sampled_r) |-> compat_mode_r == $past(fuse_s2_r))
      else $error("fuse not sampled");

   early_drop_a: assert property (
      s_early_req |=> sel_r.tgt == iocd_pkg::IOCD_TGT_NONE)
      else $error("access taken before map chosen");

   reset_idle_a: assert property (
      s_reset_exit |-> sel_r == '0 && !compat_mode_r && !map_ready_r && !ext_io_en_r && vec_count_r == 6'h00)
      else $error("outputs not idle after reset");

   map_ready_a: assert property (
      s_reset_exit |-> s_map_settle)
      else $error("map not ready two cycles after reset");

   map_steady_a: assert property (
      map_ready_r |=> map_ready_r && $stable(compat_mode_r) && $stable(vec_count_r))
      else $error("address map moved");

   vec_set_a: assert property (
      sampled_r |=> vec_count_r ==
         (compat_mode_r ? iocd_pkg::VEC_COMP_CNT : iocd_pkg::VEC_NORM_CNT))
      else $error("vector count wrong");

   pass_data_a: assert property (
      core_req.vld && sampled_r |=> sel_r.wr == $past(core_req.wr)
      && sel_r.wdata == $past(core_req.wdata))
      else $error("access data altered");
endmodule // iocd_top
`default_nettype wire

// *** iocd_pkg.sv ***
// iocd_pkg: constants and carrier types for the data-space address decoder
// assumes: 16-bit data addresses from the core, 8-bit data
package iocd_pkg;

   // ************************************************************
   // address map
   // ************************************************************
   localparam logic [15:0] IO_WIN_SIZE   = 16'h0040;  // direct i/o window, 64 locations
   localparam logic [15:0] IO_DATA_BASE  = 16'h0020;  // i/o window seen through memory accesses
   localparam logic [15:0] EXT_IO_FIRST  = 16'h0060;
   localparam logic [15:0] EXT_IO_LAST   = 16'h00ff;
   localparam logic [15:0] RAM_NORM_BASE = 16'h0100;  // first address above extended i/o
   localparam logic [15:0] RAM_COMP_BASE = 16'h0060;  // predecessor ram start
   localparam logic [15:0] RAM_SIZE      = 16'h0400;

   // ************************************************************
   // interrupt vector counts
   // ************************************************************
   localparam logic [5:0]  VEC_NORM_CNT  = 6'h1c;
   localparam logic [5:0]  VEC_COMP_CNT  = 6'h14;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef enum logic [1:0] {
      IOCD_TGT_NONE = 2'b00,
      IOCD_TGT_IO   = 2'b01,
      IOCD_TGT_EXT  = 2'b10,
      IOCD_TGT_RAM  = 2'b11
   } iocd_tgt_t;

   typedef struct packed {
      logic        vld;
      logic        io_instr;  // 1: direct i/o instruction, 0: load/store
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } iocd_req_t;

   typedef struct packed {
      iocd_tgt_t   tgt;
      logic        wr;
      logic [15:0] addr;      // offset within the selected target; extended i/o keeps the full address
      logic [7:0]  wdata;
   } iocd_sel_t;

endpackage

// *** iocd_decode.sv ***
// iocd_decode: combinational address classifier for one access
// assumes: mode is stable while accesses run
`timescale 1ns/100ps
`default_nettype none
module iocd_decode (
   // access in
   input  wire iocd_pkg::iocd_req_t req,
   input  wire logic                compat,
   // selection out
   output var iocd_pkg::iocd_sel_t  sel
);
   logic [15:0] mem_addr;

   always_comb begin
      mem_addr  = req.addr;
      sel.tgt   = iocd_pkg::IOCD_TGT_NONE;
      sel.wr    = req.wr;
      sel.wdata = req.wdata;
      sel.addr  = 16'h0000;
      if (req.vld && req.io_instr) begin
         // only 64 locations reachable; extended i/o never here
         if (req.addr < iocd_pkg::IO_WIN_SIZE) begin
            sel.tgt  = iocd_pkg::IOCD_TGT_IO;
            sel.addr = req.addr;
         end
      end else if (req.vld) begin
         if (mem_addr >= iocd_pkg::IO_DATA_BASE && mem_addr < iocd_pkg::EXT_IO_FIRST) begin
            sel.tgt  = iocd_pkg::IOCD_TGT_IO;
            sel.addr = mem_addr - iocd_pkg::IO_DATA_BASE;
         end else if (!compat && mem_addr >= iocd_pkg::EXT_IO_FIRST
                      && mem_addr <= iocd_pkg::EXT_IO_LAST) begin
            sel.tgt  = iocd_pkg::IOCD_TGT_EXT;
            sel.addr = mem_addr;
         end else if (!compat && mem_addr >= iocd_pkg::RAM_NORM_BASE
                      && mem_addr < 16'(iocd_pkg::RAM_NORM_BASE + iocd_pkg::RAM_SIZE)) begin
            sel.tgt  = iocd_pkg::IOCD_TGT_RAM;
            sel.addr = mem_addr - iocd_pkg::RAM_NORM_BASE;
         end else if (compat && mem_addr >= iocd_pkg::RAM_COMP_BASE
                      && mem_addr < 16'(iocd_pkg::RAM_COMP_BASE + iocd_pkg::RAM_SIZE)) begin
            // extended range becomes ram storage
            sel.tgt  = iocd_pkg::IOCD_TGT_RAM;
            sel.addr = mem_addr - iocd_pkg::RAM_COMP_BASE;
         end
      end
   end
endmodule // iocd_decode
`default_nettype wire

// *** iocd_core_model.sv ***
// iocd_core_model: stand-in for the core's load/store and direct i/o access path
// assumes: caller hands over one request per cycle, just after the rising edge
`timescale 1ns/100ps
`default_nettype none
module iocd_core_model (
   // access out
   output var iocd_pkg::iocd_req_t core_req
);
   initial core_req = '0;
   // extended i/o is reached by load/store; direct i/o there is only sent to be refused
   task automatic drive(input iocd_pkg::iocd_req_t r);
      core_req = r;
   endtask
endmodule // iocd_core_model
`default_nettype wire

// *** iocd_top_tb.sv ***
// iocd_top_tb: random and corner accesses in normal and compatibility maps
// assumes: design latches the fuse once per reset and answers one cycle later
`timescale 1ns/100ps
`default_nettype none
module iocd_top_tb;
   logic                sys_clk = 1'b0;
   logic                srst = 1'b1;
   logic                fuse = 1'b0;
   iocd_pkg::iocd_req_t core_req, r, p;
   iocd_pkg::iocd_sel_t sel_r, e;
   logic                compat, ext_en, ready, have;
   logic [5:0]          vec_cnt;
   int                  n_fail = 0;
   int                  num_checks = 0;
   logic [15:0]         corner [13] = '{16'h0005, 16'h003f, 16'h0040, 16'h0060, 16'h0025, 16'h005f,
                                        16'h0060, 16'h00ff, 16'h0100, 16'h04ff, 16'h0500, 16'h045f, 16'h0460};
   always #10 sys_clk = ~sys_clk;
   iocd_top dut (.sys_clk(sys_clk), .srst(srst), .legacy_compat_fuse(fuse), .core_req(core_req),
                 .sel_r(sel_r), .compat_mode_r(compat), .ext_io_en_r(ext_en), .vec_count_r(vec_cnt),
                 .map_ready_r(ready));
   iocd_core_model core (.core_req(core_req));
   // ************************************************************
   // expectation and comparison
   // ************************************************************
   function automatic iocd_pkg::iocd_sel_t exp_sel(input iocd_pkg::iocd_req_t q, input logic c);
      iocd_pkg::iocd_sel_t s;
      logic [15:0]         rb;
      s = {iocd_pkg::IOCD_TGT_NONE, q.wr, 16'h0000, q.wdata};
      rb = c ? iocd_pkg::RAM_COMP_BASE : iocd_pkg::RAM_NORM_BASE;
      if (!q.vld) begin
      end else if (q.io_instr) begin
         if (q.addr < iocd_pkg::IO_WIN_SIZE) s = {iocd_pkg::IOCD_TGT_IO, q.wr, q.addr, q.wdata};
      end else if (q.addr >= iocd_pkg::IO_DATA_BASE && q.addr < iocd_pkg::EXT_IO_FIRST) begin
         s = {iocd_pkg::IOCD_TGT_IO, q.wr, q.addr - iocd_pkg::IO_DATA_BASE, q.wdata};
      end else if (!c && q.addr >= iocd_pkg::EXT_IO_FIRST && q.addr <= iocd_pkg::EXT_IO_LAST) begin
         s = {iocd_pkg::IOCD_TGT_EXT, q.wr, q.addr, q.wdata};
      end else if (q.addr >= rb && q.addr < rb + iocd_pkg::RAM_SIZE) begin
         s = {iocd_pkg::IOCD_TGT_RAM, q.wr, q.addr - rb, q.wdata};
      end
      return s;
   endfunction
   task automatic check(input string name, input logic [26:0] seen, input logic [26:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ************************************************************
   // one reset and access run per call: normal map, compatibility map, normal map again
   // ************************************************************
   // the second call resets in mid-run, so the fuse must be relatched
   task automatic run(input logic c);
      int i;
      @(posedge sys_clk) #1;
      srst = 1'b1;
      fuse = c;
      core.drive({1'b1, 1'b0, 1'b0, iocd_pkg::RAM_NORM_BASE, 8'h00});
      repeat (12) @(posedge sys_clk);
      #1 srst = 1'b0;
      for (i = 0; i < 10 && ready !== 1'b1; i++) @(posedge sys_clk) #1;
      check("map_ready", 27'(ready), 27'h1);
      check("compat_mode", 27'(compat), 27'(c));
      check("ext_io_en", 27'(ext_en), 27'(!c));
      check("vec_count", 27'(vec_cnt), 27'(c ? iocd_pkg::VEC_COMP_CNT : iocd_pkg::VEC_NORM_CNT));
      have = 1'b0;
      for (i = 0; i < 320; i++) begin
         @(posedge sys_clk) #1;
         if (have) begin
            e = exp_sel(p, c);
            check("sel_tgt", 27'(sel_r.tgt), 27'(e.tgt));
            if (e.tgt != iocd_pkg::IOCD_TGT_NONE) check("sel", sel_r, e);
         end
         r = {1'b1, 1'b0, 1'($urandom), 16'($urandom & 32'h07ff), 8'($urandom)};
         if (i < 26) r.addr = corner[i % 13];
         r.io_instr = (i < 26) ? (i % 13 < 4) : 1'($urandom);
         if (i >= 26 && $urandom % 5 == 0) r.vld = 1'b0;
         core.drive(r);
         p = r;
         have = 1'b1;
      end
   endtask
   initial begin
      void'($urandom(35));
      run(1'b0);
      run(1'b1);
      run(1'b0);
      finish_test();
   end
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
endmodule // iocd_top_tb
`default_nettype wire
